// File: core/op_timing_pkg.sv
// shared types and constants for the standard-operation timing model
package op_timing_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int CLK_W = 10;
    localparam int CNT_W = 5;
    localparam int EA_CLK_W = 8;
    localparam int EA_CNT_W = 4;

    // ****************************************************************
    // timing constants
    // ****************************************************************
    // extra clocks when the loop-mode operand uses pre-decrement
    localparam logic [CLK_W-1:0] PREDEC_EXTRA_CLK = 10'h002;
    // one immediate extension word costs one bus read of this length
    localparam logic [CLK_W-1:0] IMM_WORD_CLK = 10'h004;
    localparam logic [CNT_W-1:0] IMM_WORD_RD = 5'h01;
    // multiply count is the worst case over operand values
    localparam logic [CLK_W-1:0] MUL_MAX_CLK = 10'h02A;
    localparam logic [CLK_W-1:0] DIV_SIGNED_CLK = 10'h07A;
    localparam logic [CLK_W-1:0] DIV_UNSIGNED_CLK = 10'h06C;
    localparam logic [CLK_W-1:0] ADD_AREG_SHORT_CLK = 10'h008;
    localparam logic [CLK_W-1:0] ADD_AREG_LOOP_CONT_CLK = 10'h012;
    localparam logic [CLK_W-1:0] ADD_AREG_LOOP_TERM_CLK = 10'h018;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [3:0] {
        op_add, op_and, op_cmp, op_eor, op_or, op_sub,
        op_signed_divide, op_unsigned_divide, op_signed_multiply, op_unsigned_multiply
    } op_e;

    typedef enum logic [1:0] {sz_byte, sz_word, sz_long} size_e;

    // destination form: ea to address reg, ea to data reg, data reg to memory
    typedef enum logic [1:0] {
        dst_address_register_operand, dst_data_register_operand, dst_memory
    } dest_e;

    typedef enum logic [1:0] {loop_none, loop_continue, loop_term_cc, loop_term_expired} loop_e;

    typedef enum logic [2:0] {
        ea_indirect, ea_postinc, ea_predec, ea_data_register_operand, ea_other
    } ea_mode_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        op_e op;
        size_e size;
        dest_e dest;
        loop_e loop;
        ea_mode_e ea_mode;
        logic [EA_CLK_W-1:0] ea_clk;
        logic [EA_CNT_W-1:0] ea_rd;
        logic [EA_CNT_W-1:0] ea_wr;
        logic [1:0] imm_words;
    } op_req_s;

    typedef struct packed {
        logic [CLK_W-1:0] clocks;
        logic [CNT_W-1:0] reads;
        logic [CNT_W-1:0] writes;
    } timing_s;

    typedef struct packed {
        logic ok;
        logic add_ea;
        timing_s t;
    } lookup_s;

endpackage

// File: core/op_timing.sv
// timing model of the standard two-operand operations
`timescale 1ns/1ps
`default_nettype none

// How it works
// - clock count covers operation, result write-back and next instruction fetch
// - flagged entries add effective-address clocks, reads and writes to the triple
// - add to address register, word: 8 clocks, 1 read, 0 writes, plus ea
// - signed divide into data register: 122 clocks, 1 read, plus ea
// - unsigned divide into data register: 108 clocks, 1 read, plus ea
// - multiply into data register: at most 42 clocks, 1 read, plus ea
// - exclusive-or into a data register takes only a data register source
// - address register destination accepts word or long only, never byte
// - loop mode: indirect, post-increment or pre-decrement only; pre-decrement adds 2
// - loop word add to address register: 18 clocks/1 read continuing, 24/3 terminating on condition, 22/3 on expiry
// - immediate operands add their instruction-stream fetch time
module op_timing (
    input wire logic clk,
    input wire logic nrst,
    input wire op_timing_pkg::op_req_s req,
    input wire logic req_valid,
    output logic req_ready,
    output op_timing_pkg::timing_s resp,
    output logic resp_valid,
    output logic resp_illegal,
    output logic busy
);
    import op_timing_pkg::*;

    // ****************************************************************
    // table helpers
    // ****************************************************************
    function automatic timing_s tm(input logic [CLK_W-1:0] c, input logic [CNT_W-1:0] r,
                                   input logic [CNT_W-1:0] w);
        timing_s t;
        t.clocks = c;
        t.reads = r;
        t.writes = w;
        return t;
    endfunction

    // choose the loop column by how the loop went
    function automatic timing_s pick3(input loop_e l, input timing_s cont, input timing_s term,
                                      input timing_s expd);
        timing_s t;
        case (l)
            loop_term_cc: t = term;
            loop_term_expired: t = expd;
            default: t = cont;
        endcase
        return t;
    endfunction

    // base entry and legality for one request, before ea and immediate words
    function automatic lookup_s lookup(input op_req_s r);
        lookup_s o;
        logic lw;
        logic alu;
        o.ok = 1'b1;
        o.add_ea = 1'b1;
        o.t = tm(10'h000, 5'h00, 5'h00);
        lw = (r.size == sz_long);
        alu = !(r.op inside {op_signed_divide, op_unsigned_divide, op_signed_multiply,
                             op_unsigned_multiply});
        // address register destinations exist only for add, subtract and compare
        if (r.dest == dst_address_register_operand) begin
            o.ok = (r.op inside {op_add, op_sub, op_cmp}) && (r.size != sz_byte);
        end else if (r.dest == dst_memory) begin
            o.ok = alu && (r.op != op_cmp);
        end else if (r.op == op_eor) begin
            o.ok = (r.ea_mode == ea_data_register_operand);
            o.add_ea = 1'b0;
        end
        if (r.loop == loop_none) begin
            case (r.dest)
                dst_address_register_operand: begin
                    if (r.op == op_cmp || lw) begin
                        o.t = tm(10'h006, 5'h01, 5'h00);
                    end else begin
                        o.t = tm(ADD_AREG_SHORT_CLK, 5'h01, 5'h00);
                    end
                end
                dst_data_register_operand: begin
                    case (r.op)
                        op_signed_divide: o.t = tm(DIV_SIGNED_CLK, 5'h01, 5'h00);
                        op_unsigned_divide: o.t = tm(DIV_UNSIGNED_CLK, 5'h01, 5'h00);
                        op_signed_multiply, op_unsigned_multiply: o.t = tm(MUL_MAX_CLK, 5'h01, 5'h00);
                        default: o.t = lw ? tm(10'h006, 5'h01, 5'h00) : tm(10'h004, 5'h01, 5'h00);
                    endcase
                end
                default: begin
                    o.t = lw ? tm(10'h00C, 5'h01, 5'h02) : tm(10'h008, 5'h01, 5'h01);
                end
            endcase
        end else begin
            // loop entries carry no ea term; operand modes are restricted
            o.add_ea = 1'b0;
            o.ok = o.ok && alu && (r.ea_mode inside {ea_indirect, ea_postinc, ea_predec});
            if (r.dest == dst_data_register_operand && r.op == op_eor) begin
                o.ok = 1'b0;
            end
            if (r.op == op_cmp) begin
                if (lw) begin
                    o.t = pick3(r.loop, tm(10'h012, 5'h02, 5'h00), tm(10'h018, 5'h04, 5'h00),
                                tm(10'h014, 5'h04, 5'h00));
                end else begin
                    o.t = pick3(r.loop, tm(10'h00C, 5'h01, 5'h00), tm(10'h012, 5'h03, 5'h00),
                                tm(10'h010, (r.dest == dst_address_register_operand) ? 5'h03 : 5'h04,
                                     5'h00));
                end
            end else if (r.dest == dst_memory) begin
                if (lw) begin
                    o.t = pick3(r.loop, tm(10'h018, 5'h02, 5'h02), tm(10'h01E, 5'h04, 5'h02),
                                tm(10'h01C, 5'h04, 5'h02));
                end else begin
                    o.t = pick3(r.loop, tm(10'h010, 5'h01, (r.op inside {op_eor, op_or}) ? 5'h00 : 5'h01),
                                tm(10'h016, 5'h03, 5'h01), tm(10'h014, 5'h03, 5'h01));
                end
            end else if (r.dest == dst_address_register_operand) begin
                if (lw) begin
                    o.t = pick3(r.loop, tm(10'h016, 5'h02, 5'h00), tm(10'h01C, 5'h04, 5'h00),
                                tm(10'h01A, 5'h04, 5'h00));
                end else begin
                    o.t = pick3(r.loop, tm(ADD_AREG_LOOP_CONT_CLK, 5'h01, 5'h00),
                                tm(ADD_AREG_LOOP_TERM_CLK, 5'h03, 5'h00), tm(10'h016, 5'h03, 5'h00));
                end
            end else if (lw && r.op == op_sub) begin
                o.t = pick3(r.loop, tm(10'h014, 5'h02, 5'h00), tm(10'h01A, 5'h04, 5'h00),
                            tm(10'h018, 5'h04, 5'h00));
            end else if (lw) begin
                o.t = pick3(r.loop, tm(10'h016, 5'h02, 5'h00), tm(10'h01C, 5'h04, 5'h00),
                            tm(10'h01A, 5'h04, 5'h00));
            end else begin
                o.t = pick3(r.loop, tm(10'h010, 5'h01, 5'h00), tm(10'h016, 5'h03, 5'h00),
                            tm(10'h014, 5'h03, 5'h00));
            end
            if (r.ea_mode == ea_predec) begin
                o.t.clocks = o.t.clocks + PREDEC_EXTRA_CLK;
            end
        end
        return o;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic {st_idle, st_busy} run_e;

    typedef struct packed {
        run_e st;
        logic [CLK_W-1:0] cnt;
        op_req_s req;
        timing_s res;
        logic valid;
        logic illegal;
    } core_s;

    core_s cur;
    core_s next_cur;
    lookup_s lk;
    timing_s total;
    logic accept;

    // total triple: table entry, ea when flagged, then immediate words
    always_comb begin
        lk = lookup(req);
        total = lk.t;
        if (lk.add_ea) begin
            total.clocks = lk.t.clocks + CLK_W'(req.ea_clk);
            total.reads = lk.t.reads + CNT_W'(req.ea_rd);
            total.writes = lk.t.writes + CNT_W'(req.ea_wr);
        end
        total.clocks = total.clocks + CLK_W'(IMM_WORD_CLK * CLK_W'(req.imm_words));
        total.reads = total.reads + CNT_W'(IMM_WORD_RD * CNT_W'(req.imm_words));
    end

    assign accept = req_valid && (cur.st == st_idle);

    // sequencer: hold busy for the full clock count, then report once
    always_comb begin
        next_cur = cur;
        next_cur.valid = 1'b0;
        case (cur.st)
            st_idle: begin
                if (accept) begin
                    next_cur.req = req;
                    if (lk.ok) begin
                        next_cur.st = st_busy;
                        next_cur.cnt = total.clocks;
                        next_cur.res = total;
                        next_cur.illegal = 1'b0;
                    end else begin
                        // refused forms answer at once with an empty triple
                        next_cur.res = '0;
                        next_cur.illegal = 1'b1;
                        next_cur.valid = 1'b1;
                    end
                end
            end
            st_busy: begin
                next_cur.cnt = cur.cnt - 1'b1;
                if (cur.cnt == 10'h001) begin
                    next_cur.st = st_idle;
                    next_cur.valid = 1'b1;
                end
            end
            default: next_cur.st = st_idle;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign req_ready = (cur.st == st_idle);
    assign busy = (cur.st == st_busy);
    assign resp = cur.res;
    assign resp_valid = cur.valid;
    assign resp_illegal = cur.illegal;

    // ****************************************************************
    // checks
    // ****************************************************************
    // busy cycles since the last accepted request, read only by the checks
    logic [CLK_W-1:0] elapsed;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            elapsed <= '0;
        end else if (accept) begin
            elapsed <= '0;
        end else if (cur.st == st_busy) begin
            elapsed <= elapsed + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_done_after_count: assert property (resp_valid && !resp_illegal |-> elapsed == resp.clocks)
        else $error("answer not aligned to its clock count");
    a_ea_reads_added: assert property (resp_valid && !resp_illegal && cur.req.loop == loop_none
        && cur.req.op != op_eor |-> resp.reads >= 5'h01 + CNT_W'(cur.req.ea_rd)
        && resp.writes >= CNT_W'(cur.req.ea_wr))
        else $error("ea counts missing from triple");
    a_addr_add_time: assert property (resp_valid && cur.req.op == op_add && cur.req.loop == loop_none
        && cur.req.dest == dst_address_register_operand && cur.req.size == sz_word
        |-> resp.clocks == 10'h008 + CLK_W'(cur.req.ea_clk) + CLK_W'(cur.req.imm_words) * 10'h004
        && resp.writes == CNT_W'(cur.req.ea_wr))
        else $error("address add timing wrong");
    a_sdiv_time: assert property (resp_valid && cur.req.op == op_signed_divide && cur.req.loop == loop_none
        && cur.req.dest == dst_data_register_operand && cur.req.imm_words == 2'h0
        |-> resp.clocks == 10'h07A + CLK_W'(cur.req.ea_clk))
        else $error("signed divide timing wrong");
    a_udiv_time: assert property (resp_valid && cur.req.op == op_unsigned_divide && cur.req.loop == loop_none
        && cur.req.dest == dst_data_register_operand && cur.req.imm_words == 2'h0
        |-> resp.clocks == 10'h06C + CLK_W'(cur.req.ea_clk) && resp.reads == 5'h01 + CNT_W'(cur.req.ea_rd))
        else $error("unsigned divide timing wrong");
    a_mul_bound: assert property (resp_valid && !resp_illegal
        && cur.req.op inside {op_signed_multiply, op_unsigned_multiply} && cur.req.imm_words == 2'h0
        |-> resp.clocks <= 10'h02A + CLK_W'(cur.req.ea_clk))
        else $error("multiply above its bound");
    a_eor_source: assert property (accept && req.op == op_eor && req.dest == dst_data_register_operand
        && req.ea_mode != ea_data_register_operand |=> resp_valid && resp_illegal)
        else $error("exclusive-or memory source accepted");
    a_areg_byte: assert property (accept && req.dest == dst_address_register_operand
        && req.size == sz_byte |=> resp_illegal)
        else $error("byte address destination accepted");
    a_loop_modes: assert property (accept && req.loop != loop_none
        && !(req.ea_mode inside {ea_indirect, ea_postinc, ea_predec}) |=> resp_illegal)
        else $error("loop mode operand mode accepted");
    a_loop_addr_add: assert property (resp_valid && cur.req.op == op_add && cur.req.size == sz_word
        && cur.req.dest == dst_address_register_operand && cur.req.ea_mode == ea_indirect
        && cur.req.loop == loop_term_cc && cur.req.imm_words == 2'h0
        |-> resp.clocks == 10'h018 && resp.reads == 5'h03)
        else $error("loop address add timing wrong");
    // a refused form taken in the answer cycle may answer in the very next cycle
    a_single_report: assert property (resp_valid && !accept |=> !resp_valid)
        else $error("answer held for more than one cycle");

    // refusal, busy window and the loop and immediate extras
    a_refused_empty: assert property (resp_valid && resp_illegal |-> resp == '0)
        else $error("refused form reported a non-empty triple");
    a_busy_after_take: assert property (accept && lk.ok |=> busy && !req_ready && !resp_valid)
        else $error("legal request not counted out");
    a_predec_extra: assert property (resp_valid && !resp_illegal && cur.req.op == op_add
        && cur.req.size == sz_word && cur.req.dest == dst_address_register_operand
        && cur.req.loop == loop_continue && cur.req.ea_mode == ea_predec && cur.req.imm_words == 2'h0
        |-> resp.clocks == 10'h014)
        else $error("pre-decrement loop extra missing");
    a_imm_fetch: assert property (resp_valid && !resp_illegal && cur.req.loop == loop_none
        && cur.req.dest == dst_data_register_operand && cur.req.op == op_or && cur.req.size == sz_word
        |-> resp.reads == 5'h01 + CNT_W'(cur.req.ea_rd) + CNT_W'(cur.req.imm_words)
        && resp.clocks == 10'h004 + CLK_W'(cur.req.ea_clk) + CLK_W'(cur.req.imm_words) * 10'h004)
        else $error("immediate word fetch time missing");
endmodule

`default_nettype wire

// File: test/op_source.sv
// request source standing in for the sequencer that feeds the timing block
`timescale 1ns/1ps
`default_nettype none

module op_source (
    input wire logic clk,
    input wire logic nrst,
    input wire op_timing_pkg::op_req_s next_req,
    input wire logic send,
    input wire logic req_ready,
    output op_timing_pkg::op_req_s req,
    output logic req_valid,
    output logic taken
);
    import op_timing_pkg::*;

    // one-cycle flag of the edge that took the request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            taken <= 1'b0;
        end else begin
            taken <= req_valid && req_ready;
        end
    end

    // hold until taken; a released descriptor flips every cycle so stale data never looks valid
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            req <= '0;
            req_valid <= 1'b0;
        end else if (!req_valid || taken) begin
            if (send) begin
                req <= next_req;
                req_valid <= 1'b1;
            end else begin
                req <= ~req;
                req_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the standard-operation timing block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import op_timing_pkg::*;

    // ****************************************************************
    // wiring and helpers
    // ****************************************************************
    localparam int LIMIT = 20000;
    localparam dest_e AREG = dst_address_register_operand;
    localparam dest_e DREG = dst_data_register_operand;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic send = 1'b0;
    logic taken;
    logic req_valid;
    logic req_ready;
    logic resp_valid;
    logic resp_illegal;
    logic busy;
    op_req_s next_req = '0;
    op_req_s req;
    timing_s resp;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    op_source op_source_inst (.clk(clk), .nrst(nrst), .next_req(next_req), .send(send),
        .req_ready(req_ready), .req(req), .req_valid(req_valid), .taken(taken));
    op_timing op_timing_inst (.clk(clk), .nrst(nrst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .resp(resp), .resp_valid(resp_valid), .resp_illegal(resp_illegal), .busy(busy));

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard: far above the several hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] expd);
        n_compared++;
        if (got !== expd) begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, expd);
        end
    endtask

    // ea cost packed as clocks, reads, writes
    function automatic op_req_s mk(op_e op, size_e sz, dest_e d, loop_e lp, ea_mode_e m,
                                   logic [15:0] ea, logic [1:0] imm);
        mk = '{op, sz, d, lp, m, ea[15:8], ea[7:4], ea[3:0], imm};
    endfunction

    function automatic timing_s tm(logic [9:0] c, logic [4:0] r, logic [4:0] w);
        tm = '{c, r, w};
    endfunction

    // called at a falling edge; returns at the falling edge that sees the take
    task automatic issue(input op_req_s r);
        int n;
        n = 0;
        next_req <= r;
        send <= 1'b1;
        @(negedge clk);
        send <= 1'b0;
        while (taken !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
    endtask

    // busy and refusal must hold every cycle until the answer pulse
    task automatic finish(input int c0, input logic ill, input timing_s e);
        int c;
        c = c0;
        while (resp_valid !== 1'b1 && c < 300) begin
            check({busy, req_ready}, 32'h2);
            @(negedge clk);
            c++;
        end
        check(32'(c), ill ? 32'h1 : 32'(e.clocks));
        check(resp_illegal, ill);
        check(resp, e);
        check(busy, 1'b0);
    endtask

    task automatic run(input op_req_s r, input timing_s e);
        issue(r);
        finish(0, 1'b0, e);
    endtask

    task automatic bad(input op_req_s r);
        issue(r);
        finish(1, 1'b1, tm(10'h000, 5'h00, 5'h00));
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_areg();
        run(mk(op_add, sz_word, AREG, loop_none, ea_indirect, 16'h0000, 2'h0), tm(10'h008, 5'h01, 5'h00));
        run(mk(op_sub, sz_word, AREG, loop_none, ea_other, 16'h0610, 2'h0), tm(10'h00E, 5'h02, 5'h00));
        run(mk(op_add, sz_long, AREG, loop_none, ea_predec, 16'h0610, 2'h0), tm(10'h00C, 5'h02, 5'h00));
        $display("test areg done");
    endtask

    task automatic t_divmul();
        run(mk(op_signed_divide, sz_word, DREG, loop_none, ea_other, 16'h0000, 2'h0), tm(10'h07A, 5'h01, 5'h00));
        run(mk(op_unsigned_divide, sz_word, DREG, loop_none, ea_other, 16'h0410, 2'h0), tm(10'h070, 5'h02, 5'h00));
        run(mk(op_signed_multiply, sz_word, DREG, loop_none, ea_other, 16'h0000, 2'h0), tm(10'h02A, 5'h01, 5'h00));
        run(mk(op_unsigned_multiply, sz_word, DREG, loop_none, ea_other, 16'h0821, 2'h0), tm(10'h032, 5'h03, 5'h01));
        $display("test divmul done");
    endtask

    task automatic t_eor();
        run(mk(op_eor, sz_word, DREG, loop_none, ea_data_register_operand, 16'h0410, 2'h0), tm(10'h004, 5'h01, 5'h00));
        bad(mk(op_eor, sz_word, DREG, loop_none, ea_indirect, 16'h0000, 2'h0));
        run(mk(op_eor, sz_long, dst_memory, loop_none, ea_postinc, 16'h0410, 2'h0), tm(10'h010, 5'h02, 5'h02));
        $display("test eor done");
    endtask

    task automatic t_byte_areg();
        op_e ops[3];
        ops = '{op_add, op_sub, op_cmp};
        foreach (ops[i]) begin
            bad(mk(ops[i], sz_byte, AREG, loop_none, ea_indirect, 16'h0000, 2'h0));
        end
        run(mk(op_cmp, sz_long, AREG, loop_none, ea_indirect, 16'h0000, 2'h0), tm(10'h006, 5'h01, 5'h00));
        $display("test byte_areg done");
    endtask

    // ea cost is ignored in loop mode; pre-decrement adds two clocks
    task automatic t_loop();
        run(mk(op_add, sz_word, AREG, loop_continue, ea_indirect, 16'h0410, 2'h0), tm(10'h012, 5'h01, 5'h00));
        run(mk(op_add, sz_word, AREG, loop_term_cc, ea_postinc, 16'h0000, 2'h0), tm(10'h018, 5'h03, 5'h00));
        run(mk(op_add, sz_word, AREG, loop_continue, ea_predec, 16'h0000, 2'h0), tm(10'h014, 5'h01, 5'h00));
        run(mk(op_add, sz_word, AREG, loop_term_expired, ea_predec, 16'h0000, 2'h0), tm(10'h018, 5'h03, 5'h00));
        run(mk(op_and, sz_long, dst_memory, loop_term_cc, ea_indirect, 16'h0000, 2'h0), tm(10'h01E, 5'h04, 5'h02));
        bad(mk(op_sub, sz_word, DREG, loop_continue, ea_other, 16'h0000, 2'h0));
        $display("test loop done");
    endtask

    task automatic t_imm();
        run(mk(op_or, sz_word, DREG, loop_none, ea_other, 16'h0000, 2'h1), tm(10'h008, 5'h02, 5'h00));
        run(mk(op_and, sz_long, DREG, loop_none, ea_other, 16'h0200, 2'h2), tm(10'h010, 5'h03, 5'h00));
        $display("test imm done");
    endtask

    // second request waits refused while busy, then is taken in the answer cycle
    task automatic t_back_to_back();
        issue(mk(op_add, sz_word, AREG, loop_none, ea_indirect, 16'h0000, 2'h0));
        next_req <= mk(op_cmp, sz_long, DREG, loop_none, ea_indirect, 16'h0000, 2'h0);
        send <= 1'b1;
        @(negedge clk);
        send <= 1'b0;
        finish(1, 1'b0, tm(10'h008, 5'h01, 5'h00));
        @(negedge clk);
        check(taken, 1'b1);
        finish(0, 1'b0, tm(10'h006, 5'h01, 5'h00));
        $display("test back_to_back done");
    endtask

    // main sequence: quiet outputs under reset, then every scenario
    initial begin
        repeat (2) @(negedge clk);
        check({req_ready, busy, resp_valid, resp_illegal}, 32'h8);
        check(resp, 32'h0);
        nrst <= 1'b1;
        @(negedge clk);
        t_areg();
        t_divmul();
        t_eor();
        t_byte_areg();
        t_loop();
        t_imm();
        t_back_to_back();
        conclude();
    end
endmodule
`default_nettype wire
